// ==== rtl/dfs_pkg.sv ====
// dual synchronous fifo: shared constants, pin vector layout, offset selection order
// assumes one 100 MHz system clock samples every pin of both channels
package dfs_pkg;

    // ==========================================================
    // widths and sizes
    localparam int DATA_W = 9;
    localparam int OFFS_W = 8;
    localparam int OFFS_REGS = 4;
    localparam int FLAG_W = 17;
    localparam int DEFAULT_DEPTH = 256;
    localparam int MIN_DEPTH = 256;
    localparam int MAX_DEPTH = 8192;
    localparam int STAGE_DEPTH = 4;

    // ==========================================================
    // offset register indices and reset values (empty and full offsets of 7)
    localparam int OFFS_EMPTY_LOW = 0;
    localparam int OFFS_EMPTY_HIGH = 1;
    localparam int OFFS_FULL_LOW = 2;
    localparam int OFFS_FULL_HIGH = 3;
    localparam logic [7:0] OFFS_RESET_LOW = 8'h07;
    localparam logic [7:0] OFFS_RESET_HIGH = 8'h00;

    // ==========================================================
    // field positions in the per-channel synchronised pin vector
    localparam int PIN_DATA = 0;
    localparam int PIN_WEN1 = 9;
    localparam int PIN_WEN2 = 10;
    localparam int PIN_REN1 = 11;
    localparam int PIN_REN2 = 12;
    localparam int PIN_OE = 13;
    localparam int PIN_WCLK = 14;
    localparam int PIN_RCLK = 15;
    localparam int PIN_RST = 16;
    localparam int PIN_W = 17;

    // ==========================================================
    // offset register selection, gray coded along its cycle
    typedef enum logic [1:0] {
        DFS_SEL_EMPTY_LOW = 2'h0,
        DFS_SEL_EMPTY_HIGH = 2'h1,
        DFS_SEL_FULL_LOW = 2'h3,
        DFS_SEL_FULL_HIGH = 2'h2
    } dfs_sel_e;

    // next register in the fixed four-step order, wrapping to the start
    function automatic dfs_sel_e dfs_next_sel(input dfs_sel_e sel);
        case (sel)
            DFS_SEL_EMPTY_LOW: dfs_next_sel = DFS_SEL_EMPTY_HIGH;
            DFS_SEL_EMPTY_HIGH: dfs_next_sel = DFS_SEL_FULL_LOW;
            DFS_SEL_FULL_LOW: dfs_next_sel = DFS_SEL_FULL_HIGH;
            default: dfs_next_sel = DFS_SEL_EMPTY_LOW;
        endcase
    endfunction : dfs_next_sel

    // array index of the selected offset register
    function automatic logic [1:0] dfs_sel_idx(input dfs_sel_e sel);
        case (sel)
            DFS_SEL_EMPTY_LOW: dfs_sel_idx = 2'(OFFS_EMPTY_LOW);
            DFS_SEL_EMPTY_HIGH: dfs_sel_idx = 2'(OFFS_EMPTY_HIGH);
            DFS_SEL_FULL_LOW: dfs_sel_idx = 2'(OFFS_FULL_LOW);
            default: dfs_sel_idx = 2'(OFFS_FULL_HIGH);
        endcase
    endfunction : dfs_sel_idx

endpackage : dfs_pkg

// ==== rtl/dfs_stream_if.sv ====
// valid/ready word stream between the channel logic and its staging buffer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface dfs_stream_if #(
    parameter int WIDTH = 9
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : dfs_stream_if
`default_nettype wire

// ==== rtl/dfs_stage_fifo.sv ====
// small staging fifo placed between captured writes and the storage array
// assumes same clock on both sides; flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none
module dfs_stage_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // clock, reset and freeze
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic flush,
    // fill and drain sides
    dfs_stream_if.sink push,
    dfs_stream_if.source pop
);
    import dfs_pkg::*;

    localparam int PW = $clog2(DEPTH);

    // ==========================================================
    // state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] slot;
        logic [PW:0] wr;
        logic [PW:0] rd;
    } dfs_stage_s;

    dfs_stage_s st;
    dfs_stage_s next_st;
    logic full;
    logic empty;

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("staging depth must be a power of two, two or more");
    end

    // full when the pointers differ only in the wrap bit
    assign full = (st.wr[PW] != st.rd[PW]) && (st.wr[PW-1:0] == st.rd[PW-1:0]);
    assign empty = (st.wr == st.rd);
    assign push.ready = !full;
    assign pop.valid = !empty;
    assign pop.data = st.slot[st.rd[PW-1:0]];

    // ==========================================================
    // pointer and slot update
    always_comb begin
        next_st = st;
        if (flush) begin
            next_st.wr = '0;
            next_st.rd = '0;
        end else begin
            if (push.valid && !full) begin
                next_st.slot[st.wr[PW-1:0]] = push.data;
                next_st.wr = st.wr + 1'b1;
            end
            if (pop.ready && !empty) begin
                next_st.rd = st.rd + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ==========================================================
    // checks
    no_overrun_a: assert property (@(posedge clk) disable iff (!reset_n)
        (st.wr - st.rd) <= (PW+1)'(DEPTH))
        else $error("staging fifo holds more words than its depth");

endmodule : dfs_stage_fifo
`default_nettype wire

// ==== rtl/dfs_dual_fifo.sv ====
// dual synchronous fifo: two independent 9-bit channels with programmable flags
// assumes every pin is asynchronous to clk; the write and read clocks are
// sampled and their rising edges detected, so they must run well below clk/2
//
// Functional notes
// [RL1] two arrays, each with own pointers
// [RL2] channel reset empties it, empty flag low
// [RL3] data outputs low after reset release
// [RL4] user resets after power-up, no traffic then
// [RL5] load pin high at reset: second enable
// [RL6] load pin low at reset: offset load
// [RL7] flag mode: write when enable one low
// [RL8] two-enable mode: write on both enables
// [RL9] both read enables low: next word out
// [RL10] output enable high floats the outputs
// [RL11] writes ignored full, reads ignored empty
// [RL12] empty channel keeps last read word
// [RL13] four offset registers written in fixed order
// [RL14] offset selection persists across load high
// [RL15] load and read enables low: offset readback
// [RL16] user avoids offset write and read together
// [RL17] almost empty low at n or fewer
// [RL18] almost full low at depth minus m
// [RL19] almost empty change may slip one edge
// [RL20] almost full change may slip one edge
// [RL21] offsets default to seven after reset
// [RL22] full flag low when full, write edges
// [RL23] empty flag low blocks data reads; offset readback still runs while empty
// [RL24] readback uses the same selection order
// [RL25] depth parameter 256 to 8192 words
// [RL26] pin clocks synchronised before any logic
`timescale 1ns/1ps
`default_nettype none
module dfs_dual_fifo #(
    parameter int DEPTH = dfs_pkg::DEFAULT_DEPTH
) (
    // system clock, reset and freeze
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // channel a write side
    input wire logic write_clock_a,
    input wire logic write_en1_n_a,
    input wire logic write_en2_or_load_a,
    input wire logic [dfs_pkg::DATA_W-1:0] input_word_a,
    // channel a read side
    input wire logic read_clock_a,
    input wire logic read_en1_n_a,
    input wire logic read_en2_n_a,
    input wire logic output_enable_n_a,
    input wire logic reset_n_fifo_a,
    output logic [dfs_pkg::DATA_W-1:0] output_word_a,
    output logic output_word_drive_n_a,
    // channel a flags
    output logic empty_flag_n_a,
    output logic full_flag_n_a,
    output logic almost_empty_n_a,
    output logic almost_full_n_a,
    // channel b write side
    input wire logic write_clock_b,
    input wire logic write_en1_n_b,
    input wire logic write_en2_or_load_b,
    input wire logic [dfs_pkg::DATA_W-1:0] input_word_b,
    // channel b read side
    input wire logic read_clock_b,
    input wire logic read_en1_n_b,
    input wire logic read_en2_n_b,
    input wire logic output_enable_n_b,
    input wire logic reset_n_fifo_b,
    output logic [dfs_pkg::DATA_W-1:0] output_word_b,
    output logic output_word_drive_n_b,
    // channel b flags
    output logic empty_flag_n_b,
    output logic full_flag_n_b,
    output logic almost_empty_n_b,
    output logic almost_full_n_b
);
    import dfs_pkg::*;

    localparam int AW = $clog2(DEPTH);

    typedef logic [AW:0] dfs_ptr_t;

    localparam dfs_ptr_t DEPTH_P = dfs_ptr_t'(DEPTH);

    // ==========================================================
    // state: one record per channel
    typedef struct packed {
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic wclk_prev;
        logic rclk_prev;
        logic prog_mode;
        dfs_sel_e sel;
        logic [OFFS_REGS-1:0][OFFS_W-1:0] offs;
        dfs_ptr_t acc_ptr;
        dfs_ptr_t wptr;
        dfs_ptr_t rptr;
        logic empty_n;
        logic full_n;
        logic ae_n;
        logic af_n;
        logic [DATA_W-1:0] q;
        logic q_drive_n;
    } dfs_chan_s;

    typedef struct packed {
        dfs_chan_s [1:0] ch;
    } dfs_state_s;

    localparam dfs_chan_s CH_RESET = '{
        offs: {OFFS_RESET_HIGH, OFFS_RESET_LOW, OFFS_RESET_HIGH, OFFS_RESET_LOW},
        full_n: 1'b1,
        af_n: 1'b1,
        q_drive_n: 1'b1,
        sync1: PIN_W'(1) << PIN_RST, // reset pin idles high: no phantom channel reset
        sync2: PIN_W'(1) << PIN_RST,
        sel: DFS_SEL_EMPTY_LOW,
        default: '0
    };

    dfs_state_s st;
    dfs_state_s next_st;
    logic [DATA_W-1:0] mem [2][DEPTH];
    logic [1:0][PIN_W-1:0] pins;
    logic [1:0][DATA_W-1:0] mem_q;
    logic [1:0] push_valid;
    logic [1:0][DATA_W-1:0] push_data;
    logic [1:0] push_ready;
    logic [1:0] pop_valid;
    logic [1:0][DATA_W-1:0] pop_data;
    logic [1:0] pop_ready;
    logic [1:0] flush;
    logic [1:0] wedge_c;
    logic [1:0] redge_c;

    if (DEPTH < MIN_DEPTH || DEPTH > MAX_DEPTH || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("depth must be a power of two from 256 to 8192"); // RL25
    end

    // strictly greater compare at flag width; both offsets and counts fit in it
    function automatic logic dfs_above(input logic [FLAG_W-1:0] a, input logic [FLAG_W-1:0] b);
        dfs_above = a > b;
    endfunction : dfs_above

    // ==========================================================
    // pin gathering
    assign pins[0] = {reset_n_fifo_a, read_clock_a, write_clock_a, output_enable_n_a,
                      read_en2_n_a, read_en1_n_a, write_en2_or_load_a, write_en1_n_a,
                      input_word_a};
    assign pins[1] = {reset_n_fifo_b, read_clock_b, write_clock_b, output_enable_n_b,
                      read_en2_n_b, read_en1_n_b, write_en2_or_load_b, write_en1_n_b,
                      input_word_b};

    // asynchronous array read at each channel's read pointer
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            mem_q[c] = mem[c][st.ch[c].rptr[AW-1:0]];
        end
    end

    // ==========================================================
    // channel behaviour
    always_comb begin
        dfs_chan_s s;
        dfs_chan_s n;
        logic [PIN_W-1:0] p;
        logic wedge;
        logic redge;
        logic load_n;
        dfs_ptr_t stored;
        dfs_ptr_t total;
        logic [FLAG_W-1:0] n_off;
        logic [FLAG_W-1:0] m_off;
        s = '0;
        n = '0;
        p = '0;
        wedge = 1'b0;
        redge = 1'b0;
        load_n = 1'b1;
        stored = '0;
        total = '0;
        n_off = '0;
        m_off = '0;
        next_st = st;
        push_valid = '0;
        push_data = '0;
        pop_ready = '0;
        flush = '0;
        wedge_c = '0;
        redge_c = '0;
        for (int c = 0; c < 2; c++) begin
            s = st.ch[c];
            n = s;
            // two flops on every pin, edges found on the second stage only
            n.sync1 = pins[c]; // RL26
            n.sync2 = s.sync1;
            p = s.sync2;
            wedge = p[PIN_WCLK] && !s.wclk_prev;
            redge = p[PIN_RCLK] && !s.rclk_prev;
            n.wclk_prev = p[PIN_WCLK];
            n.rclk_prev = p[PIN_RCLK];
            wedge_c[c] = wedge;
            redge_c[c] = redge;
            load_n = p[PIN_WEN2];
            n.q_drive_n = p[PIN_OE]; // RL10
            stored = s.wptr - s.rptr;
            // drain stalls while the array is full so staging really fills
            pop_ready[c] = stored < DEPTH_P;
            if (pop_valid[c] && pop_ready[c]) begin
                n.wptr = s.wptr + 1'b1;
            end
            if (!p[PIN_RST]) begin
                // channel reset: empty, defaults, mode strap taken from the load pin
                n = CH_RESET; // RL2 RL21
                n.sync1 = pins[c];
                n.sync2 = s.sync1;
                n.wclk_prev = p[PIN_WCLK];
                n.rclk_prev = p[PIN_RCLK];
                n.q_drive_n = p[PIN_OE];
                n.prog_mode = !p[PIN_WEN2]; // RL5 RL6
                flush[c] = 1'b1; // RL3
            end else begin
                if (wedge && !p[PIN_WEN1]) begin
                    if (s.prog_mode && !load_n) begin
                        // offset write, selection persists while load is high
                        n.offs[dfs_sel_idx(s.sel)] = p[PIN_DATA +: OFFS_W]; // RL13
                        n.sel = dfs_next_sel(s.sel); // RL14
                    end else if ((s.prog_mode || p[PIN_WEN2]) && s.full_n && push_ready[c]) begin
                        push_valid[c] = 1'b1; // RL7 RL8 RL11
                        push_data[c] = p[PIN_DATA +: DATA_W];
                        n.acc_ptr = s.acc_ptr + 1'b1;
                    end
                end
                if (redge && !p[PIN_REN1] && !p[PIN_REN2]) begin
                    if (s.prog_mode && !load_n) begin
                        // readback continues from any selection a write just moved
                        n.q = {1'b0, s.offs[dfs_sel_idx(n.sel)]}; // RL15 RL24
                        n.sel = dfs_next_sel(n.sel);
                    end else if (s.empty_n && stored != '0) begin
                        n.q = mem_q[c]; // RL9 RL23 RL12
                        n.rptr = s.rptr + 1'b1;
                    end
                end
                // flags only move on their own clock edge; a late edge slips one
                stored = n.wptr - n.rptr;
                total = n.acc_ptr - n.rptr;
                n_off = FLAG_W'({s.offs[OFFS_EMPTY_HIGH], s.offs[OFFS_EMPTY_LOW]});
                m_off = FLAG_W'({s.offs[OFFS_FULL_HIGH], s.offs[OFFS_FULL_LOW]});
                if (redge) begin
                    n.empty_n = stored != '0; // RL23
                    n.ae_n = dfs_above(FLAG_W'(stored), n_off); // RL17 RL19
                end
                if (wedge) begin
                    n.full_n = total < DEPTH_P; // RL22 RL11
                    n.af_n = dfs_above(FLAG_W'(DEPTH_P) - FLAG_W'(total), m_off); // RL18 RL20
                end
            end
            next_st.ch[c] = n;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{ch: '{CH_RESET, CH_RESET}};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // storage arrays, written from the staging drain; no reset on purpose
    always_ff @(posedge clk) begin
        for (int c = 0; c < 2; c++) begin
            if (clk_en && pop_valid[c] && pop_ready[c]) begin
                mem[c][st.ch[c].wptr[AW-1:0]] <= pop_data[c]; // RL1
            end
        end
    end

    // ==========================================================
    // staging buffers and per-channel checks
    for (genvar g = 0; g < 2; g++) begin : g_ch
        dfs_stream_if #(.WIDTH(DATA_W)) push_if ();
        dfs_stream_if #(.WIDTH(DATA_W)) pop_if ();

        assign push_if.valid = push_valid[g];
        assign push_if.data = push_data[g];
        assign push_ready[g] = push_if.ready;
        assign pop_valid[g] = pop_if.valid;
        assign pop_data[g] = pop_if.data;
        assign pop_if.ready = pop_ready[g];

        dfs_stage_fifo #(
            .WIDTH(DATA_W),
            .DEPTH(STAGE_DEPTH)
        ) u_stage (
            .clk(clk),
            .reset_n(reset_n),
            .clk_en(clk_en),
            .flush(flush[g]),
            .push(push_if),
            .pop(pop_if)
        );

        empty_in_reset_a: assert property (@(posedge clk) disable iff (!reset_n) // RL2
            (clk_en && !st.ch[g].sync2[PIN_RST]) |=> !st.ch[g].empty_n && st.ch[g].full_n)
            else $error("channel reset did not empty the channel");

        output_low_reset_a: assert property (@(posedge clk) disable iff (!reset_n) // RL3
            (clk_en && !st.ch[g].sync2[PIN_RST]) |=> (st.ch[g].q == '0))
            else $error("data output not cleared by channel reset");

        mode_strap_a: assert property (@(posedge clk) disable iff (!reset_n) // RL5
            (clk_en && !st.ch[g].sync2[PIN_RST])
            |=> (st.ch[g].prog_mode == !$past(st.ch[g].sync2[PIN_WEN2])))
            else $error("mode not taken from load pin during reset");

        no_overflow_a: assert property (@(posedge clk) disable iff (!reset_n) // RL11
            ((st.ch[g].acc_ptr - st.ch[g].rptr) <= DEPTH_P)
            && ((st.ch[g].wptr - st.ch[g].rptr) <= DEPTH_P))
            else $error("channel pointers overran the depth");

        read_needs_data_a: assert property (@(posedge clk) disable iff (!reset_n) // RL23
            ($changed(st.ch[g].rptr) && st.ch[g].rptr != '0) |-> $past(st.ch[g].empty_n))
            else $error("read taken while empty flag was low");

        offset_order_a: assert property (@(posedge clk) disable iff (!reset_n) // RL13
            ($changed(st.ch[g].offs) && $past(st.ch[g].sync2[PIN_RST]))
            |-> (st.ch[g].sel == dfs_next_sel($past(st.ch[g].sel))))
            else $error("offset selection did not step in order");

        hold_when_empty_a: assert property (@(posedge clk) disable iff (!reset_n) // RL12
            (!st.ch[g].empty_n && !st.ch[g].prog_mode && st.ch[g].sync2[PIN_RST])
            |=> $stable(st.ch[g].q))
            else $error("output word changed while channel empty");

        almost_empty_a: assert property (@(posedge clk) disable iff (!reset_n) // RL17
            (clk_en && redge_c[g] && st.ch[g].sync2[PIN_RST]) |=> (st.ch[g].ae_n ==
            (dfs_ptr_t'(st.ch[g].wptr - st.ch[g].rptr) >
             {st.ch[g].offs[OFFS_EMPTY_HIGH], st.ch[g].offs[OFFS_EMPTY_LOW]})))
            else $error("almost empty flag wrong after read edge");

        almost_full_a: assert property (@(posedge clk) disable iff (!reset_n) // RL18
            (clk_en && wedge_c[g] && st.ch[g].sync2[PIN_RST]) |=> (st.ch[g].af_n ==
            ((FLAG_W'(DEPTH_P) - FLAG_W'(dfs_ptr_t'(st.ch[g].acc_ptr - st.ch[g].rptr))) >
             FLAG_W'({st.ch[g].offs[OFFS_FULL_HIGH], st.ch[g].offs[OFFS_FULL_LOW]}))))
            else $error("almost full flag wrong after write edge");
    end

    // ==========================================================
    // outputs, all straight from state
    assign output_word_a = st.ch[0].q;
    assign output_word_drive_n_a = st.ch[0].q_drive_n;
    assign empty_flag_n_a = st.ch[0].empty_n;
    assign full_flag_n_a = st.ch[0].full_n;
    assign almost_empty_n_a = st.ch[0].ae_n;
    assign almost_full_n_a = st.ch[0].af_n;
    assign output_word_b = st.ch[1].q;
    assign output_word_drive_n_b = st.ch[1].q_drive_n;
    assign empty_flag_n_b = st.ch[1].empty_n;
    assign full_flag_n_b = st.ch[1].full_n;
    assign almost_empty_n_b = st.ch[1].ae_n;
    assign almost_full_n_b = st.ch[1].af_n;

endmodule : dfs_dual_fifo
`default_nettype wire

// ==== verif/dfs_partner_model.sv ====
// partner model: producer and consumer pins of one fifo channel
// assumes clk is the system clock; pin clocks run free, as documented
`timescale 1ns/1ps
`default_nettype none
module dfs_partner_model (
    // system clock
    input wire logic clk,
    // channel pins
    output logic write_clock,
    output logic write_en1_n,
    output logic write_en2_or_load,
    output logic [dfs_pkg::DATA_W-1:0] input_word,
    output logic read_clock,
    output logic read_en1_n,
    output logic read_en2_n,
    output logic reset_n_fifo
);
    import dfs_pkg::*;
    // ==========================================================
    // idle pins; read clock phase kept apart from the write clock
    initial begin
        {write_en1_n, write_en2_or_load, read_en1_n, read_en2_n, reset_n_fifo} = 5'h1f;
        input_word = 9'h0aa;
        write_clock = 1'b0;
        read_clock = 1'b0;
        fork
            forever #80 write_clock = ~write_clock;
            #37 forever #80 read_clock = ~read_clock;
        join
    end
    // ==========================================================
    // falling edge on reset, strap held, no traffic meanwhile
    task automatic chan_reset(input logic strap);
        @(posedge clk);
        reset_n_fifo <= 1'b0;
        write_en2_or_load <= strap;
        repeat (6) @(posedge clk);
        reset_n_fifo <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : chan_reset
    task automatic set_load(input logic v);
        @(posedge clk);
        write_en2_or_load <= v;
        repeat (40) @(posedge clk);
    endtask : set_load
    // data released to its inverse so a stale word never looks valid
    task automatic wr(input logic [8:0] d, input logic e2);
        @(negedge write_clock);
        @(posedge clk);
        write_en1_n <= 1'b0;
        write_en2_or_load <= e2;
        input_word <= d;
        @(posedge write_clock);
        @(posedge clk);
        write_en1_n <= 1'b1;
        input_word <= ~d;
    endtask : wr
    task automatic rd();
        @(negedge read_clock);
        @(posedge clk);
        read_en1_n <= 1'b0;
        read_en2_n <= 1'b0;
        @(posedge read_clock);
        @(posedge clk);
        read_en1_n <= 1'b1;
        read_en2_n <= 1'b1;
    endtask : rd
endmodule : dfs_partner_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// testbench: channel a in flag mode, channel b in two-enable mode
// assumes the partner model drives each channel's pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dfs_pkg::*;
    typedef struct packed {logic [8:0] din; logic en2;} dfs_row_s;
    localparam dfs_row_s ROWS [10] = '{'{9'h1ff, 1'b1}, '{9'h000, 1'b1}, '{9'h155, 1'b1},
        '{9'h0aa, 1'b0}, '{9'h100, 1'b1}, '{9'h001, 1'b1}, '{9'h0fe, 1'b1},
        '{9'h033, 1'b1}, '{9'h180, 1'b1}, '{9'h07c, 1'b1}};
    localparam logic [8:0] OFFS [5] = '{9'h002, 9'h000, 9'h003, 9'h000, 9'h001};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic oe [2] = '{1'b0, 1'b0};
    logic wc [2], we1 [2], we2 [2], rc [2], re1 [2], re2 [2], rs [2];
    logic drv [2], ef [2], ff [2], ae [2], af [2];
    logic [8:0] din [2], dout [2];
    logic [8:0] q [$];
    logic [8:0] last;
    int err_total = 0;
    int compares = 0;
    always #5 clk = ~clk;
    // ==========================================================
    // one partner per channel, a at index 0
    for (genvar i = 0; i < 2; i++) begin : g
        dfs_partner_model dfs_partner_model_inst (.clk(clk), .write_clock(wc[i]),
            .write_en1_n(we1[i]), .write_en2_or_load(we2[i]), .input_word(din[i]),
            .read_clock(rc[i]), .read_en1_n(re1[i]), .read_en2_n(re2[i]), .reset_n_fifo(rs[i]));
    end
    dfs_dual_fifo #(.DEPTH(256)) dfs_dual_fifo_inst (.clk(clk), .reset_n(reset_n),
        .clk_en(clk_en), .write_clock_a(wc[0]), .write_en1_n_a(we1[0]),
        .write_en2_or_load_a(we2[0]), .input_word_a(din[0]), .read_clock_a(rc[0]),
        .read_en1_n_a(re1[0]), .read_en2_n_a(re2[0]), .output_enable_n_a(oe[0]),
        .reset_n_fifo_a(rs[0]), .output_word_a(dout[0]), .output_word_drive_n_a(drv[0]),
        .empty_flag_n_a(ef[0]), .full_flag_n_a(ff[0]), .almost_empty_n_a(ae[0]),
        .almost_full_n_a(af[0]), .write_clock_b(wc[1]), .write_en1_n_b(we1[1]),
        .write_en2_or_load_b(we2[1]), .input_word_b(din[1]), .read_clock_b(rc[1]),
        .read_en1_n_b(re1[1]), .read_en2_n_b(re2[1]), .output_enable_n_b(oe[1]),
        .reset_n_fifo_b(rs[1]), .output_word_b(dout[1]), .output_word_drive_n_b(drv[1]),
        .empty_flag_n_b(ef[1]), .full_flag_n_b(ff[1]), .almost_empty_n_b(ae[1]),
        .almost_full_n_b(af[1]));
    // ==========================================================
    // shared helpers
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic st();
        repeat (40) @(posedge clk);
    endtask : st
    task automatic wr(input int c, input logic [8:0] d, input logic e);
        if (c == 0) g[0].dfs_partner_model_inst.wr(d, e);
        else g[1].dfs_partner_model_inst.wr(d, e);
    endtask : wr
    // output settles about three clk after the read clock edge
    task automatic rd(input int c);
        if (c == 0) g[0].dfs_partner_model_inst.rd();
        else g[1].dfs_partner_model_inst.rd();
        repeat (6) @(posedge clk);
    endtask : rd
    task automatic give_verdict();
        $display("err_total=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // watchdog: the sequence needs roughly 10000 clk, three times that is allowed
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        give_verdict();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        g[0].dfs_partner_model_inst.chan_reset(1'b0);
        g[1].dfs_partner_model_inst.chan_reset(1'b1);
        for (int c = 0; c < 2; c++) begin
            chk(ef[c], 9'h000);
            chk({drv[c], ff[c], af[c], ae[c]}, 9'h006);
            chk(dout[c], 9'h000);
        end
        // table rows: second enable low must not store
        foreach (ROWS[i]) begin
            wr(1, ROWS[i].din, ROWS[i].en2);
            if (ROWS[i].en2) q.push_back(ROWS[i].din);
        end
        while (q.size() > 0) begin
            st();
            chk(ae[1], 9'(q.size() > 7));
            rd(1);
            last = q.pop_front();
            chk(dout[1], last);
        end
        st();
        chk(ef[1], 9'h000);
        rd(1);
        chk(dout[1], last);
        // fill to the top, one refused word, drain in order
        for (int i = 0; i < 257; i++) wr(1, (i < 256) ? 9'(i) : 9'h1ab, 1'b1);
        st();
        chk({ff[1], af[1]}, 9'h000);
        for (int i = 0; i < 256; i++) begin
            rd(1);
            chk(dout[1], 9'(i));
            if (i == 0) begin
                st();
                chk(ff[1], 9'h001);
            end
        end
        // refused word must not appear; mid-run reset clears a nonzero output
        st();
        chk(ef[1], 9'h000);
        g[1].dfs_partner_model_inst.chan_reset(1'b1);
        chk(dout[1], 9'h000);
        // five offset writes wrap; selection survives load high
        foreach (OFFS[i]) wr(0, OFFS[i], 1'b0);
        g[0].dfs_partner_model_inst.set_load(1'b1);
        g[0].dfs_partner_model_inst.set_load(1'b0);
        for (int i = 1; i < 5; i++) begin
            rd(0);
            chk(dout[0], OFFS[i]);
        end
        // flag mode data with n of one
        wr(0, 9'h011, 1'b1);
        st();
        chk(ae[0], 9'h000);
        wr(0, 9'h122, 1'b1);
        st();
        chk(ae[0], 9'h001);
        // a low clock enable freezes every flop, the drive flop included
        @(posedge clk) clk_en <= 1'b0;
        oe[0] <= 1'b1;
        repeat (6) @(posedge clk);
        chk(drv[0], 9'h000);
        clk_en <= 1'b1;
        repeat (6) @(posedge clk);
        chk(drv[0], 9'h001);
        oe[0] <= 1'b0;
        repeat (6) @(posedge clk);
        chk(drv[0], 9'h000);
        rd(0);
        chk(dout[0], 9'h011);
        rd(0);
        chk(dout[0], 9'h122);
        st();
        chk(ef[0], 9'h000);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
